// >>> shared/ftsf_params.svh
`ifndef FTSF_PARAMS_SVH
`define FTSF_PARAMS_SVH
// Register offsets within the device map
`define FTSF_OFS_REG_FAULT  8'hB3
`define FTSF_OFS_CRIT_TEMP  8'hB4
`define FTSF_OFS_HOT_TEMP   8'hB5
`define FTSF_OFS_OVERCUR    8'hB6
// Reset value of every flag register
`define FTSF_RST_FLAGS      8'h00
// Writable flag masks; other bits are reserved
`define FTSF_MSK_REG_FAULT  8'h19
`define FTSF_MSK_TEMP       8'h1F
`define FTSF_MSK_OVERCUR    8'h07
// Field positions
`define FTSF_BIT_RAIL_A1    4
`define FTSF_BIT_TERM       3
`define FTSF_BIT_RAIL_A3    0
`define FTSF_BIT_CTRL6      2
`define FTSF_BIT_CTRL2      1
`define FTSF_BIT_CTRL1      0
`define FTSF_NUM_SENSORS    5
`endif

// >>> shared/ftsf_pkg.sv
`default_nettype none
package ftsf_pkg;
	// One register access from the serial-interface front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ftsf_req_t;

	// Detector outputs, one bit per analog comparator
	typedef struct packed {
		logic       rail_a1_regulation_lost;
		logic       termination_regulation_lost;
		logic       rail_a3_regulation_lost;
		logic [4:0] sensor_critical;  // Index = register bit
		logic [4:0] sensor_warm;
		logic       controller6_lowside_overcurrent;
		logic       controller2_lowside_overcurrent;
		logic       controller1_lowside_overcurrent;
	} ftsf_det_t;
endpackage
`default_nettype wire

// >>> src/ftsf_flags.sv
`include "ftsf_params.svh"
`default_nettype none
module ftsf_flags #(
	parameter int NUM_SENSORS = `FTSF_NUM_SENSORS
) (
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	input  wire ftsf_pkg::ftsf_req_t req_i,
	input  wire ftsf_pkg::ftsf_det_t det_i,
	output logic [7:0]               rdata_o,
	output logic                     rvalid_o
);
	// The field map is fixed to five sensors; refuse any other count
	if (NUM_SENSORS != `FTSF_NUM_SENSORS) begin : g_bad_sensors
		$error("ftsf_flags serves exactly five sensors");
	end

	logic [7:0] reg_fault;
	logic [7:0] crit_temp;
	logic [7:0] hot_temp;
	logic [7:0] overcur;
	logic [7:0] ev_reg;
	logic [7:0] ev_crit;
	logic [7:0] ev_hot;
	logic [7:0] ev_oc;

	// Decoded clear pattern: ones only where the write hits a flag bit
	function automatic logic [7:0] clr_bits(input ftsf_pkg::ftsf_req_t r,
			input logic [7:0] ofs, input logic [7:0] msk);
		clr_bits = (r.wr && r.addr == ofs) ? (r.wdata & msk) : 8'h00;
	endfunction

	// Sticky update; set term is ORed last so an event beats a clear
	function automatic logic [7:0] next_flags(input logic [7:0] cur,
			input logic [7:0] clr, input logic [7:0] ev,
			input logic [7:0] msk);
		next_flags = ((cur & ~clr) | ev) & msk;
	endfunction

	// Map detector lines to register bit positions
	always_comb begin
		ev_reg = 8'h00;
		ev_reg[`FTSF_BIT_RAIL_A1] = det_i.rail_a1_regulation_lost;
		ev_reg[`FTSF_BIT_TERM] = det_i.termination_regulation_lost;
		ev_reg[`FTSF_BIT_RAIL_A3] = det_i.rail_a3_regulation_lost;
		ev_crit = {3'h0, det_i.sensor_critical};
		ev_hot = {3'h0, det_i.sensor_warm};
		ev_oc = 8'h00;
		ev_oc[`FTSF_BIT_CTRL6] = det_i.controller6_lowside_overcurrent;
		ev_oc[`FTSF_BIT_CTRL2] = det_i.controller2_lowside_overcurrent;
		ev_oc[`FTSF_BIT_CTRL1] = det_i.controller1_lowside_overcurrent;
	end

	// Regulation fault flags; reserved bits masked off so they stay 0
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_fault <= `FTSF_RST_FLAGS;
		end else begin
			reg_fault <= next_flags(reg_fault,
				clr_bits(req_i, `FTSF_OFS_REG_FAULT, `FTSF_MSK_REG_FAULT),
				ev_reg, `FTSF_MSK_REG_FAULT);
		end
	end

	// Critical temperature flags
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			crit_temp <= `FTSF_RST_FLAGS;
		end else begin
			crit_temp <= next_flags(crit_temp,
				clr_bits(req_i, `FTSF_OFS_CRIT_TEMP, `FTSF_MSK_TEMP),
				ev_crit, `FTSF_MSK_TEMP);
		end
	end

	// Warm temperature flags
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hot_temp <= `FTSF_RST_FLAGS;
		end else begin
			hot_temp <= next_flags(hot_temp,
				clr_bits(req_i, `FTSF_OFS_HOT_TEMP, `FTSF_MSK_TEMP),
				ev_hot, `FTSF_MSK_TEMP);
		end
	end

	// Overcurrent flags
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overcur <= `FTSF_RST_FLAGS;
		end else begin
			overcur <= next_flags(overcur,
				clr_bits(req_i, `FTSF_OFS_OVERCUR, `FTSF_MSK_OVERCUR),
				ev_oc, `FTSF_MSK_OVERCUR);
		end
	end

	// Registered read port; unmapped offsets read zero so other
	// registers of the map can be muxed in by the front end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= `FTSF_RST_FLAGS;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			if (!req_i.rd)
				rdata_o <= 8'h00;
			else if (req_i.addr == `FTSF_OFS_REG_FAULT)
				rdata_o <= reg_fault;
			else if (req_i.addr == `FTSF_OFS_CRIT_TEMP)
				rdata_o <= crit_temp;
			else if (req_i.addr == `FTSF_OFS_HOT_TEMP)
				rdata_o <= hot_temp;
			else if (req_i.addr == `FTSF_OFS_OVERCUR)
				rdata_o <= overcur;
			else
				rdata_o <= 8'h00;
		end
	end

	// All checks run on the core clock and rest while reset is held
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_event_sets: assert property (
		det_i.rail_a1_regulation_lost |=> reg_fault[`FTSF_BIT_RAIL_A1])
		else $error("rail a1 event not latched");
	a_flag_sticky: assert property (
		crit_temp[0] && !(req_i.wr && req_i.addr == `FTSF_OFS_CRIT_TEMP
		&& req_i.wdata[0]) |=> crit_temp[0])
		else $error("critical flag dropped without clear");
	a_w1c_clears: assert property (
		req_i.wr && req_i.addr == `FTSF_OFS_OVERCUR && req_i.wdata[2]
		&& !det_i.controller6_lowside_overcurrent |=> !overcur[2])
		else $error("write one did not clear");
	a_crit_map: assert property (
		det_i.sensor_critical[4] |=> crit_temp[4])
		else $error("die critical not latched");
	a_hot_map: assert property (
		det_i.sensor_warm[3] |=> hot_temp[3])
		else $error("termination warm not latched");
	a_sensor_split: assert property (
		det_i.sensor_warm[2] && !det_i.sensor_critical[2]
		&& !crit_temp[2] |=> !crit_temp[2])
		else $error("warm event leaked into critical");
	a_oc_map: assert property (
		det_i.controller1_lowside_overcurrent |=> overcur[0])
		else $error("controller1 overcurrent not latched");
	a_reserved_zero: assert property (
		hot_temp[7:5] == 3'h0 && crit_temp[7:5] == 3'h0
		&& overcur[7:3] == 5'h00
		&& reg_fault[7:5] == 3'h0 && reg_fault[2:1] == 2'h0)
		else $error("reserved bit set");
	a_set_wins: assert property (
		req_i.wr && req_i.addr == `FTSF_OFS_HOT_TEMP && req_i.wdata[1]
		&& det_i.sensor_warm[1] |=> hot_temp[1])
		else $error("clear beat a same-cycle event");
	a_zero_write: assert property (
		req_i.wr && req_i.addr == `FTSF_OFS_REG_FAULT && req_i.wdata == 8'h00
		|=> (reg_fault & $past(reg_fault)) == $past(reg_fault))
		else $error("zero write changed flags");
	a_read_data: assert property (
		req_i.rd && req_i.addr == `FTSF_OFS_OVERCUR
		|=> rvalid_o && rdata_o == $past(overcur))
		else $error("read data mismatch");

	// Every mapped regulation line must reach its own bit
	a_term_sets: assert property (
		det_i.termination_regulation_lost |=> reg_fault[`FTSF_BIT_TERM])
		else $error("termination regulation event not latched");
	a_rail_a3_sets: assert property (
		det_i.rail_a3_regulation_lost |=> reg_fault[`FTSF_BIT_RAIL_A3])
		else $error("rail a3 event not latched");

	// A quiet detector never raises a flag on its own
	a_no_false_set: assert property (
		!det_i.rail_a1_regulation_lost && !reg_fault[`FTSF_BIT_RAIL_A1]
		|=> !reg_fault[`FTSF_BIT_RAIL_A1])
		else $error("rail a1 flag set with no fault");

	// Without a write to the register no flag of it may fall
	a_no_stray_clear: assert property (
		!(req_i.wr && req_i.addr == `FTSF_OFS_REG_FAULT)
		|=> (reg_fault & $past(reg_fault)) == $past(reg_fault))
		else $error("regulation flag dropped without clear");

	// The two remaining controllers of the overcurrent register
	a_oc_ctrl6: assert property (
		det_i.controller6_lowside_overcurrent |=> overcur[`FTSF_BIT_CTRL6])
		else $error("controller6 overcurrent not latched");
	a_oc_ctrl2: assert property (
		det_i.controller2_lowside_overcurrent |=> overcur[`FTSF_BIT_CTRL2])
		else $error("controller2 overcurrent not latched");

	// Each sensor owns the same bit in both temperature registers, so
	// a wiring slip between the two vectors shows up here first
	for (genvar s = 0; s < NUM_SENSORS; s++) begin : g_sensor_chk
		a_crit_each: assert property (
			det_i.sensor_critical[s] |=> crit_temp[s])
			else $error("critical sensor event not latched");
		a_warm_each: assert property (
			det_i.sensor_warm[s] |=> hot_temp[s])
			else $error("warm sensor event not latched");
	end

	// Main scenarios: latch, clear, collision, readback, read with write
	c_crit_event: cover property (det_i.sensor_critical[0] ##1 crit_temp[0]);
	c_clear: cover property (overcur[1] ##1 req_i.wr ##1 !overcur[1]);
	c_collide: cover property (req_i.wr && req_i.addr == `FTSF_OFS_HOT_TEMP
		&& det_i.sensor_warm != 5'h00);
	c_read: cover property (rvalid_o && rdata_o != 8'h00);
	c_read_write: cover property (req_i.wr && req_i.rd);
endmodule
`default_nettype wire

// >>> testbench/fault_thermal_status_flags_bench.sv
`default_nettype none
module fault_thermal_status_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                core_clk_i = 1'b0;
	logic                rst_n_i = 1'b0;
	ftsf_pkg::ftsf_req_t req;
	ftsf_pkg::ftsf_det_t det = '0;
	logic [7:0]          rdata;
	logic                rvalid;
	logic [7:0]          want;
	logic                rd_q = 1'b0;
	logic [7:0]          flags [4] = '{default: 8'h00};
	logic [7:0]          expq [$];
	int                  n_fail = 0;
	int                  comparisons = 0;

	always #4 core_clk_i = ~core_clk_i;

	ftsf_host host (.clk_i(core_clk_i), .req_o(req));
	ftsf_flags dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.req_i(req), .det_i(det), .rdata_o(rdata), .rvalid_o(rvalid));

	// Detector bits as they land in each register
	function automatic logic [7:0] ev(input int r,
		input ftsf_pkg::ftsf_det_t d);
		case (r)
			0: ev = {3'h0, d.rail_a1_regulation_lost,
				d.termination_regulation_lost, 2'h0,
				d.rail_a3_regulation_lost};
			1: ev = {3'h0, d.sensor_critical};
			2: ev = {3'h0, d.sensor_warm};
			3: ev = {5'h0, d.controller6_lowside_overcurrent,
				d.controller2_lowside_overcurrent,
				d.controller1_lowside_overcurrent};
			default: ev = 8'h00;
		endcase
	endfunction

	// Random cycle; sparse events so that clears can be seen
	task automatic step();
		logic       wr;
		logic       rd;
		logic [7:0] a;
		logic [7:0] d;
		int         r;
		wr = 1'($urandom);
		rd = 1'($urandom);
		a = 8'hB2 + 8'($urandom % 6);
		d = 8'($urandom);
		r = int'(a) - int'(8'hB3);
		host.put(wr, rd, a, d);
		det = ftsf_pkg::ftsf_det_t'(16'($urandom & $urandom & $urandom));
		// A read shows the value from before this edge
		if (rd) begin
			expq.push_back((r >= 0 && r < 4) ? flags[r] : 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			flags[i] = (flags[i] & ~((wr && r == i) ? d : 8'h00))
				| ev(i, det);
		end
	endtask

	// Read strobe as the block saw it; its answer comes one edge later
	always @(posedge core_clk_i) rd_q <= req.rd;

	// Answers are taken at the falling edge, where they are settled
	always @(negedge core_clk_i) begin
		if (rvalid === 1'b1) begin
			want = (expq.size() > 0) ? expq.pop_front() : 8'hFF;
		end else begin
			want = 8'h00;
		end
		comparisons++;
		if (rdata !== want) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, rdata, want);
		end
		comparisons++;
		if (rvalid !== rd_q) begin
			n_fail++;
			$display("BAD %0t rvalid got %h exp %h", $time, rvalid, rd_q);
		end
	end

	task automatic stop_test();
		if (expq.size() != 0) begin
			n_fail++;
		end
		$display("checks %0d errors %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Two runs, the second after a reset once traffic has stopped
	initial begin
		void'($urandom(32'h0633));
		for (int k = 0; k < 2; k++) begin
			repeat (5) @(posedge core_clk_i);
			#1;
			rst_n_i = 1'b1;
			for (int i = 0; i < 4; i++) begin
				host.put(1'b0, 1'b1, 8'hB3 + 8'(i), 8'h00);
				expq.push_back(8'h00);
			end
			repeat (300) step();
			host.put(1'b0, 1'b0, 8'h00, 8'h00);
			det = '0;
			repeat (2) @(posedge core_clk_i);
			#1;
			rst_n_i = 1'b0;
			flags = '{default: 8'h00};
		end
		stop_test();
	end

	// Watchdog well beyond the roughly 620 cycles of traffic
	initial begin
		#20000;
		n_fail++;
		stop_test();
	end
endmodule
`default_nettype wire

// >>> testbench/ftsf_host.sv
`default_nettype none
module ftsf_host (
	input  wire logic              clk_i,
	output var ftsf_pkg::ftsf_req_t req_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Nothing is requested until the first call
	initial req_o = '0;

	// A request stands until the next call, so calls can run back to back
	task automatic put(input logic wr, input logic rd,
		input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		#1;
		req_o = {wr, rd, addr, data};
	endtask
endmodule
`default_nettype wire
